/* File: oad_cfg.svh */
// offsets, field positions, reset values and address ranges of the outbound address decoder
`ifndef OAD_CFG_SVH
`define OAD_CFG_SVH

// --------------------------------------------------------------
// register word offsets (byte addresses)
// --------------------------------------------------------------
`define OAD_OFS_LOW_MMIO 8'h00
`define OAD_OFS_HIGH_MMIO 8'h04
`define OAD_OFS_CFG_WIN 8'h08
`define OAD_OFS_NODE_CTRL 8'h0c
`define OAD_OFS_STATUS 8'h10

// --------------------------------------------------------------
// field positions and reset values
// --------------------------------------------------------------
`define OAD_WIN_EN_BIT 31
`define OAD_FWH_DIS_BIT 0
`define OAD_NODE_LSB 8
`define OAD_NODE_MSB 12
`define OAD_RST_LOW_MMIO 32'hf000_0000
`define OAD_RST_HIGH_MMIO 32'h0000_0000
`define OAD_RST_CFG_WIN 32'h0000_0000
`define OAD_RST_NODE_CTRL 32'h0000_0000

// --------------------------------------------------------------
// destination attribute codes
// --------------------------------------------------------------
`define OAD_ATTR_NONE 4'h0
`define OAD_ATTR_MMIO 4'h2
`define OAD_ATTR_CB 4'h4
`define OAD_ATTR_INT 4'h1

// --------------------------------------------------------------
// fixed address ranges, 40-bit
// --------------------------------------------------------------
`define OAD_4G_TOP 40'h00_ffff_ffff
`define OAD_LMMIO_TOP 40'h00_fdff_ffff
`define OAD_CHIP_LO 40'h00_fe00_0000
`define OAD_CHIP_HI 40'h00_febf_ffff
`define OAD_IRQC_LO 40'h00_fec0_0000
`define OAD_IRQC_HI 40'h00_fecf_ffff
`define OAD_RSV1_LO 40'h00_fed0_0000
`define OAD_RSV1_HI 40'h00_fedf_ffff
`define OAD_MSG_LO 40'h00_fee0_0000
`define OAD_MSG_HI 40'h00_feef_ffff
`define OAD_RSV2_LO 40'h00_fef0_0000
`define OAD_RSV2_HI 40'h00_feff_ffff
`define OAD_GFW_LO 40'h00_ff00_0000
`define OAD_GFW_HI 40'h00_ffbf_ffff
`define OAD_LFW_LO 40'h00_ffc0_0000
`define OAD_LFW_HI 40'h00_ffff_ffff
`define OAD_HMMIO_TOP 40'hff_ffff_ffff
`define OAD_CFG_WIN_SIZE 40'h00_0400_0000
`define OAD_LOCAL_REG_SIZE 40'h00_0000_1000

`endif

/* File: oad_pkg.sv */
// types shared by the outbound address decoder
`default_nettype none
package oad_pkg;

    // disposition of one processor request, one-hot
    typedef enum logic [8:0] {
        OAD_MEM = 9'h001,
        OAD_LOCAL_REG = 9'h002,
        OAD_PORT_NC = 9'h004,
        OAD_PORT_CFG = 9'h008,
        OAD_FW_HUB = 9'h010,
        OAD_DROP = 9'h020,
        OAD_IRQ_LOCAL = 9'h040,
        OAD_IRQ_REDIR = 9'h080,
        OAD_IRQ_PORT = 9'h100
    } oad_disp_t;

    // request from the processor bus
    typedef struct packed {
        logic valid;
        logic [39:0] addr;
        logic is_write;
        logic is_irq;
        logic redirectable;
    } oad_req_t;

    // decision handed to the routing logic
    typedef struct packed {
        logic valid;
        oad_disp_t disp;
        logic [3:0] attr;
        logic [39:0] addr;
        logic is_write;
        logic [4:0] dest_node;
    } oad_dec_t;

    // interrupt message arriving from the port
    typedef struct packed {
        logic valid;
        logic [39:0] addr;
        logic redirectable;
    } oad_irq_t;

    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } oad_bus_t;

    // all state of the decoder
    typedef struct packed {
        logic [31:0] low_mmio_base;
        logic [31:0] high_mmio_base;
        logic [31:0] cfg_window_base;
        logic [31:0] node_init_control_reg;
        logic fwh_strap;
        oad_dec_t dec;
        logic irq_present;
        logic irq_redirect;
        logic [31:0] rdata;
    } oad_state_t;

endpackage
`default_nettype wire

/* File: oad_decoder.sv */
// outbound address decoder: routes processor requests and interrupt messages
`default_nettype none
`include "oad_cfg.svh"

// Functional notes
// - above low mmio base up to FDFF_FFFF: non-coherent to port, mmio attribute
// - chipset range hitting a local register: local configuration access, not forwarded
// - chipset range missing local registers: non-coherent to port, compat-bus attribute
// - interrupt-controller window: non-coherent to port, mmio attribute
// - reserved FEDx range: writes dropped, reads to port with compat-bus attribute
// - memory access to FEEx and any FEFx access: port, compat-bus attribute
// - interrupt transactions to FEEx go to interrupt message routing
// - global firmware range: non-coherent to port, compat-bus attribute
// - local firmware range: firmware hub when enabled, else port compat-bus
// - firmware hub disabled by strap or by node control bit
// - enabled high mmio window up to FF_FFFF_FFFF: port, mmio attribute
// - enabled 64 MB config window: local register or port configuration access
// - anything else: coherent request to main memory
// - incoming message for node A[8:4]: presented directly, or redirected here
// - local directed interrupt to own node completes locally, not sent
// - local redirectable interrupt to own node is redirected here, not sent
// - directed interrupt for another node is sent to the port
// - redirectable interrupt for another node is sent for remote redirection
// - attribute codes: 0010 mmio, 0100 compat bus, 0001 interrupt
module oad_decoder
    import oad_pkg::*;
#(
    parameter logic [39:0] LOCAL_REG_SIZE = `OAD_LOCAL_REG_SIZE
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic firmware_hub_enable_strap_in,
    input wire oad_bus_t bus_in,
    output logic [31:0] bus_rdata_out,
    input wire oad_req_t req_in,
    output logic req_ready_out,
    output oad_dec_t dec_out,
    input wire oad_irq_t irq_in,
    output logic irq_present_out,
    output logic irq_redirect_out,
    output logic fw_hub_enabled_out
);

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    oad_state_t q;
    oad_state_t d;

    // --------------------------------------------------------------
    // window decode terms
    // --------------------------------------------------------------
    logic [39:0] a;
    logic [39:0] low_base;
    logic [39:0] high_base;
    logic [39:0] cfg_base;
    logic [4:0] own_node;
    logic fwh_en;
    logic in_low_mmio;
    logic in_chip;
    logic chip_reg_hit;
    logic in_irqc;
    logic in_rsv1;
    logic in_msg;
    logic in_rsv2;
    logic in_gfw;
    logic in_lfw;
    logic in_high_mmio;
    logic in_cfg;
    logic cfg_local;

    // base registers widened to full addresses
    assign a = req_in.addr;
    assign low_base = {8'h00, q.low_mmio_base};
    assign high_base = {q.high_mmio_base[19:0], 20'h0_0000};
    assign cfg_base = {q.cfg_window_base[13:0], 26'h000_0000};
    assign own_node = q.node_init_control_reg[`OAD_NODE_MSB:`OAD_NODE_LSB];

    // firmware hub usable only if strap and control bit both allow it
    assign fwh_en = q.fwh_strap && !q.node_init_control_reg[`OAD_FWH_DIS_BIT];

    // range compares on the whole 40-bit address
    assign in_low_mmio = (a > low_base) && (a <= `OAD_LMMIO_TOP);
    assign in_chip = (a >= `OAD_CHIP_LO) && (a <= `OAD_CHIP_HI);
    assign chip_reg_hit = in_chip && ((a - `OAD_CHIP_LO) < LOCAL_REG_SIZE);
    assign in_irqc = (a >= `OAD_IRQC_LO) && (a <= `OAD_IRQC_HI);
    assign in_rsv1 = (a >= `OAD_RSV1_LO) && (a <= `OAD_RSV1_HI);
    assign in_msg = (a >= `OAD_MSG_LO) && (a <= `OAD_MSG_HI);
    assign in_rsv2 = (a >= `OAD_RSV2_LO) && (a <= `OAD_RSV2_HI);
    assign in_gfw = (a >= `OAD_GFW_LO) && (a <= `OAD_GFW_HI);
    assign in_lfw = (a >= `OAD_LFW_LO) && (a <= `OAD_LFW_HI);
    assign in_high_mmio = q.high_mmio_base[`OAD_WIN_EN_BIT] && (a >= high_base)
        && (a <= `OAD_HMMIO_TOP);
    assign in_cfg = q.cfg_window_base[`OAD_WIN_EN_BIT] && (a >= cfg_base)
        && ((a - cfg_base) < `OAD_CFG_WIN_SIZE);
    assign cfg_local = (a - cfg_base) < LOCAL_REG_SIZE;

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        d = q;
        d.dec.valid = 1'b0;
        d.irq_present = 1'b0;
        d.irq_redirect = 1'b0;
        d.rdata = 32'h0000_0000;

        // register writes
        if (bus_in.wr) begin
            case (bus_in.addr)
                `OAD_OFS_LOW_MMIO: d.low_mmio_base = bus_in.wdata;
                `OAD_OFS_HIGH_MMIO: d.high_mmio_base = bus_in.wdata;
                `OAD_OFS_CFG_WIN: d.cfg_window_base = bus_in.wdata;
                `OAD_OFS_NODE_CTRL: d.node_init_control_reg = bus_in.wdata;
                default: d.low_mmio_base = q.low_mmio_base;
            endcase
        end

        // register reads, data valid next cycle, unmapped reads zero
        if (bus_in.rd) begin
            case (bus_in.addr)
                `OAD_OFS_LOW_MMIO: d.rdata = q.low_mmio_base;
                `OAD_OFS_HIGH_MMIO: d.rdata = q.high_mmio_base;
                `OAD_OFS_CFG_WIN: d.rdata = q.cfg_window_base;
                `OAD_OFS_NODE_CTRL: d.rdata = q.node_init_control_reg;
                `OAD_OFS_STATUS: d.rdata = {22'h00_0000, fwh_en, q.dec.disp};
                default: d.rdata = 32'h0000_0000;
            endcase
        end

        // request decode, one disposition in priority order
        if (req_in.valid) begin
            d.dec.valid = 1'b1;
            d.dec.addr = a;
            d.dec.is_write = req_in.is_write;
            d.dec.attr = `OAD_ATTR_NONE;
            d.dec.dest_node = own_node;
            d.dec.disp = OAD_MEM;
            if (in_msg && req_in.is_irq) begin
                d.dec.dest_node = a[8:4];
                d.dec.attr = `OAD_ATTR_INT;
                if (a[19:15] != own_node) begin
                    d.dec.disp = OAD_IRQ_PORT;
                end else if (req_in.redirectable) begin
                    d.dec.disp = OAD_IRQ_REDIR;
                end else begin
                    d.dec.disp = OAD_IRQ_LOCAL;
                end
            end else if (chip_reg_hit) begin
                d.dec.disp = OAD_LOCAL_REG;
            end else if (in_chip || in_msg || in_rsv2 || in_gfw) begin
                d.dec.disp = OAD_PORT_NC;
                d.dec.attr = `OAD_ATTR_CB;
            end else if (in_irqc) begin
                d.dec.disp = OAD_PORT_NC;
                d.dec.attr = `OAD_ATTR_MMIO;
            end else if (in_rsv1) begin
                if (req_in.is_write) begin
                    d.dec.disp = OAD_DROP;
                end else begin
                    d.dec.disp = OAD_PORT_NC;
                    d.dec.attr = `OAD_ATTR_CB;
                end
            end else if (in_lfw) begin
                if (fwh_en) begin
                    d.dec.disp = OAD_FW_HUB;
                end else begin
                    d.dec.disp = OAD_PORT_NC;
                    d.dec.attr = `OAD_ATTR_CB;
                end
            end else if (in_cfg) begin
                d.dec.disp = cfg_local ? OAD_LOCAL_REG : OAD_PORT_CFG;
            end else if (in_low_mmio) begin
                d.dec.disp = OAD_PORT_NC;
                d.dec.attr = `OAD_ATTR_MMIO;
            end else if (in_high_mmio) begin
                d.dec.disp = OAD_PORT_NC;
                d.dec.attr = `OAD_ATTR_MMIO;
            end else begin
                d.dec.disp = OAD_MEM;
            end
        end

        // incoming interrupt message for this node
        if (irq_in.valid && irq_in.addr[8:4] == own_node) begin
            d.irq_present = !irq_in.redirectable;
            d.irq_redirect = irq_in.redirectable;
        end

        // strap is sampled while reset is held
        if (srst_in) begin
            d.low_mmio_base = `OAD_RST_LOW_MMIO;
            d.high_mmio_base = `OAD_RST_HIGH_MMIO;
            d.cfg_window_base = `OAD_RST_CFG_WIN;
            d.node_init_control_reg = `OAD_RST_NODE_CTRL;
            d.fwh_strap = firmware_hub_enable_strap_in;
            d.dec = '0;
            d.dec.disp = OAD_MEM;
            d.irq_present = 1'b0;
            d.irq_redirect = 1'b0;
            d.rdata = 32'h0000_0000;
        end
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        q <= d;
    end

    // outputs
    assign req_ready_out = 1'b1; // decoder never stalls
    assign dec_out = q.dec;
    assign bus_rdata_out = q.rdata;
    assign irq_present_out = q.irq_present;
    assign irq_redirect_out = q.irq_redirect;
    assign fw_hub_enabled_out = fwh_en;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    chk_low_mmio_route: assert property (@(posedge clk_in) disable iff (srst_in)
        req_in.valid && !req_in.is_irq && in_low_mmio && !in_cfg
        |=> dec_out.valid && dec_out.disp == OAD_PORT_NC && dec_out.attr == 4'h2)
        else $error("low mmio request not sent to port with mmio attribute");

    chk_local_reg_hit: assert property (@(posedge clk_in) disable iff (srst_in)
        req_in.valid && chip_reg_hit |=> dec_out.disp == OAD_LOCAL_REG)
        else $error("local register hit was forwarded");

    chk_chip_miss_cb: assert property (@(posedge clk_in) disable iff (srst_in)
        req_in.valid && in_chip && !chip_reg_hit
        |=> dec_out.disp == OAD_PORT_NC && dec_out.attr == 4'h4)
        else $error("chipset range miss not sent with compat attribute");

    chk_irqc_mmio: assert property (@(posedge clk_in) disable iff (srst_in)
        req_in.valid && in_irqc |=> dec_out.attr == 4'h2 && dec_out.disp == OAD_PORT_NC)
        else $error("interrupt controller window misrouted");

    chk_rsv_write_drop: assert property (@(posedge clk_in) disable iff (srst_in)
        req_in.valid && in_rsv1 |=> (dec_out.disp == OAD_DROP) == $past(req_in.is_write))
        else $error("reserved range write not dropped or read dropped");

    chk_irq_to_routing: assert property (@(posedge clk_in) disable iff (srst_in)
        req_in.valid && in_msg && req_in.is_irq
        |=> dec_out.attr == 4'h1 && dec_out.dest_node == $past(req_in.addr[8:4]))
        else $error("interrupt not handed to message routing");

    chk_local_irq_kept: assert property (@(posedge clk_in) disable iff (srst_in)
        req_in.valid && in_msg && req_in.is_irq && req_in.addr[19:15] == own_node
        |=> dec_out.disp != OAD_IRQ_PORT)
        else $error("own node interrupt sent to port");

    chk_remote_irq_out: assert property (@(posedge clk_in) disable iff (srst_in)
        req_in.valid && in_msg && req_in.is_irq && req_in.addr[19:15] != own_node
        |=> dec_out.disp == OAD_IRQ_PORT)
        else $error("remote interrupt not sent to port");

    chk_fw_hub_gate: assert property (@(posedge clk_in) disable iff (srst_in)
        dec_out.valid && dec_out.disp == OAD_FW_HUB |-> $past(fwh_en))
        else $error("firmware hub used while disabled");

    chk_in_irq_sel: assert property (@(posedge clk_in) disable iff (srst_in)
        irq_in.valid && irq_in.addr[8:4] == own_node
        |=> irq_present_out != irq_redirect_out)
        else $error("incoming message for this node not delivered");

    chk_default_mem: assert property (@(posedge clk_in) disable iff (srst_in)
        req_in.valid && a > `OAD_4G_TOP && !in_cfg && !in_high_mmio
        |=> dec_out.disp == OAD_MEM && dec_out.attr == 4'h0)
        else $error("unmatched request not sent to memory");

    chk_one_disp: assert property (@(posedge clk_in) disable iff (srst_in)
        dec_out.valid |-> $onehot(dec_out.disp))
        else $error("decision not exactly one disposition");

endmodule
`default_nettype wire

/* File: oad_bus_model.sv */
// processor bus and port side model: issues requests and incoming interrupt messages
`default_nettype none
module oad_bus_model
    import oad_pkg::*;
(
    input wire logic clk_in,
    output var oad_req_t req_out,
    output var oad_irq_t irq_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // --------------------------------------------------------------
    // request and message drivers
    // --------------------------------------------------------------
    // both buses start idle
    initial begin
        req_out = '0;
        irq_out = '0;
    end

    // one request for one cycle; released fields are inverted so stale values never match
    task automatic issue(input logic [39:0] a, input logic w, input logic i, input logic r);
        @(posedge clk_in);
        req_out <= '{1'b1, a, w, i, r};
        @(posedge clk_in);
        req_out <= '{1'b0, ~a, ~w, ~i, ~r};
    endtask

    // one interrupt message arriving from the port, same one-cycle framing
    task automatic message(input logic [39:0] a, input logic r);
        @(posedge clk_in);
        irq_out <= '{1'b1, a, r};
        @(posedge clk_in);
        irq_out <= '{1'b0, ~a, ~r};
    endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the outbound address decoder
`default_nettype none
`include "oad_cfg.svh"
module testbench
    import oad_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // --------------------------------------------------------------
    // signals and instances
    // --------------------------------------------------------------
    logic clk_in;
    logic srst_in;
    logic strap;
    oad_bus_t bus;
    oad_req_t req;
    oad_irq_t irq;
    oad_dec_t dec_out;
    logic [31:0] rdata;
    logic req_ready;
    logic irq_present;
    logic irq_redirect;
    logic fw_hub_en;
    int err_count = 0;
    int compares = 0;

    oad_decoder oad_decoder_i (
        .clk_in(clk_in), .srst_in(srst_in), .firmware_hub_enable_strap_in(strap),
        .bus_in(bus), .bus_rdata_out(rdata), .req_in(req), .req_ready_out(req_ready),
        .dec_out(dec_out), .irq_in(irq), .irq_present_out(irq_present),
        .irq_redirect_out(irq_redirect), .fw_hub_enabled_out(fw_hub_en)
    );

    oad_bus_model oad_bus_model_i (.clk_in(clk_in), .req_out(req), .irq_out(irq));

    // 10 MHz clock
    always #50 clk_in = ~clk_in;

    // --------------------------------------------------------------
    // compare, bus and report tasks
    // --------------------------------------------------------------
    task automatic cmp_val(input string n, input logic [39:0] e, input logic [39:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cmp_dec(input oad_disp_t d, input logic [3:0] a, input logic ca);
        compares++;
        if (dec_out.valid !== 1'b1 || dec_out.disp !== d || (ca && dec_out.attr !== a)) begin
            err_count++;
            $display("CHECK FAILED dec_out expected %h/%h seen %h/%h", d, a, dec_out.disp, dec_out.attr);
        end
    endtask

    // one request, then judge the decision in the cycle after it
    task automatic dec_case(input logic [39:0] a, input logic w, input logic i, input logic r,
                            input oad_disp_t d, input logic [3:0] at, input logic ca);
        oad_bus_model_i.issue(a, w, i, r);
        #1;
        cmp_dec(d, at, ca);
        cmp_val("dec_addr", a, dec_out.addr);
        cmp_val("dec_is_write", {39'h0, w}, {39'h0, dec_out.is_write});
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_in);
        bus.wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge clk_in);
        bus.rd <= 1'b0;
        #1;
        cmp_val("rdata", {8'h00, e}, {8'h00, rdata});
    endtask

    task automatic do_reset(input logic s);
        @(posedge clk_in);
        srst_in <= 1'b1;
        strap <= s;
        repeat (16) @(posedge clk_in);
        srst_in <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    // register reset values and the unmapped hole
    task automatic t_reset_values();
        rd_reg(`OAD_OFS_LOW_MMIO, 32'hf000_0000);
        rd_reg(`OAD_OFS_HIGH_MMIO, 32'h0000_0000);
        rd_reg(`OAD_OFS_CFG_WIN, 32'h0000_0000);
        rd_reg(`OAD_OFS_NODE_CTRL, 32'h0000_0000);
        rd_reg(`OAD_OFS_STATUS, 32'h0000_0201);
        rd_reg(8'h20, 32'h0000_0000);
        cmp_val("req_ready", 40'h1, {39'h0, req_ready});
    endtask

    // fixed ranges at both edges (FEEx at its lower edge only), reads and writes
    task automatic t_fixed_ranges();
        dec_case(40'h00_f000_0000, 0, 0, 0, OAD_MEM, 4'h0, 0);
        dec_case(40'h00_f000_0001, 1, 0, 0, OAD_PORT_NC, 4'h2, 1);
        dec_case(40'h00_fdff_ffff, 0, 0, 0, OAD_PORT_NC, 4'h2, 1);
        dec_case(40'h00_fe00_0000, 1, 0, 0, OAD_LOCAL_REG, 4'h0, 0);
        dec_case(40'h00_fe00_0fff, 0, 0, 0, OAD_LOCAL_REG, 4'h0, 0);
        dec_case(40'h00_fe00_1000, 0, 0, 0, OAD_PORT_NC, 4'h4, 1);
        dec_case(40'h00_febf_ffff, 1, 0, 0, OAD_PORT_NC, 4'h4, 1);
        dec_case(40'h00_fec0_0000, 0, 0, 0, OAD_PORT_NC, 4'h2, 1);
        dec_case(40'h00_fecf_ffff, 1, 0, 0, OAD_PORT_NC, 4'h2, 1);
        dec_case(40'h00_fed0_0000, 1, 0, 0, OAD_DROP, 4'h0, 0);
        dec_case(40'h00_fedf_ffff, 0, 0, 0, OAD_PORT_NC, 4'h4, 1);
        dec_case(40'h00_fee0_0000, 1, 0, 0, OAD_PORT_NC, 4'h4, 1);
        dec_case(40'h00_fef0_0000, 0, 0, 0, OAD_PORT_NC, 4'h4, 1);
        dec_case(40'h00_feff_ffff, 1, 0, 0, OAD_PORT_NC, 4'h4, 1);
        dec_case(40'h00_ff00_0000, 0, 0, 0, OAD_PORT_NC, 4'h4, 1);
        dec_case(40'h00_ffbf_ffff, 1, 0, 0, OAD_PORT_NC, 4'h4, 1);
        dec_case(40'h00_ffc0_0000, 0, 0, 0, OAD_FW_HUB, 4'h0, 0);
        dec_case(40'h00_ffff_ffff, 1, 0, 0, OAD_FW_HUB, 4'h0, 0);
        dec_case(40'h01_fe00_0000, 0, 0, 0, OAD_MEM, 4'h0, 0);
        dec_case(40'hff_ffff_ffff, 0, 0, 0, OAD_MEM, 4'h0, 0);
    endtask

    // firmware hub disabled by control bit, then by strap
    task automatic t_fw_hub();
        wr_reg(`OAD_OFS_NODE_CTRL, 32'h0000_0001);
        #1 cmp_val("fw_hub_enabled", 40'h0, {39'h0, fw_hub_en});
        dec_case(40'h00_ffc0_0000, 0, 0, 0, OAD_PORT_NC, 4'h4, 1);
        rd_reg(`OAD_OFS_STATUS, 32'h0000_0004);
        do_reset(1'b0);
        rd_reg(`OAD_OFS_NODE_CTRL, 32'h0000_0000);
        cmp_val("fw_hub_enabled", 40'h0, {39'h0, fw_hub_en});
        dec_case(40'h00_ffff_ffff, 1, 0, 0, OAD_PORT_NC, 4'h4, 1);
        do_reset(1'b1);
        #1 cmp_val("fw_hub_enabled", 40'h1, {39'h0, fw_hub_en});
    endtask

    // high mmio window at base 02_0000_0000, config window at 4000_0000, low mmio base moved
    task automatic t_windows();
        wr_reg(`OAD_OFS_HIGH_MMIO, 32'h8000_2000); // base field holds address bits 39:20
        wr_reg(`OAD_OFS_CFG_WIN, 32'h8000_0010);
        rd_reg(`OAD_OFS_CFG_WIN, 32'h8000_0010);
        rd_reg(`OAD_OFS_HIGH_MMIO, 32'h8000_2000);
        dec_case(40'h01_ffff_ffff, 0, 0, 0, OAD_MEM, 4'h0, 0);
        dec_case(40'h02_0000_0000, 1, 0, 0, OAD_PORT_NC, 4'h2, 1);
        dec_case(40'hff_ffff_ffff, 0, 0, 0, OAD_PORT_NC, 4'h2, 1);
        dec_case(40'h00_4000_0fff, 0, 0, 0, OAD_LOCAL_REG, 4'h0, 0);
        dec_case(40'h00_4000_1000, 1, 0, 0, OAD_PORT_CFG, 4'h0, 0);
        dec_case(40'h00_43ff_ffff, 0, 0, 0, OAD_PORT_CFG, 4'h0, 0);
        dec_case(40'h00_4400_0000, 0, 0, 0, OAD_MEM, 4'h0, 0);
        wr_reg(`OAD_OFS_LOW_MMIO, 32'he000_0000);
        rd_reg(`OAD_OFS_LOW_MMIO, 32'he000_0000);
        dec_case(40'h00_e000_0000, 1, 0, 0, OAD_MEM, 4'h0, 0);
        dec_case(40'h00_e000_0001, 0, 0, 0, OAD_PORT_NC, 4'h2, 1);
    endtask

    // outgoing interrupts from node 3 to node 9, and incoming messages
    task automatic t_irq();
        wr_reg(`OAD_OFS_NODE_CTRL, 32'h0000_0300);
        dec_case(40'h00_fee1_8090, 1, 1, 0, OAD_IRQ_LOCAL, 4'h1, 1);
        dec_case(40'h00_fee1_8090, 1, 1, 1, OAD_IRQ_REDIR, 4'h1, 1);
        dec_case(40'h00_fee2_8090, 1, 1, 0, OAD_IRQ_PORT, 4'h1, 1);
        cmp_val("dest_node", 40'h9, {35'h0, dec_out.dest_node});
        dec_case(40'h00_fee2_8090, 1, 1, 1, OAD_IRQ_PORT, 4'h1, 1);
        oad_bus_model_i.message(40'h00_fee0_0030, 1'b0);
        #1 cmp_val("irq_present", 40'h1, {39'h0, irq_present});
        cmp_val("irq_redirect", 40'h0, {39'h0, irq_redirect});
        oad_bus_model_i.message(40'h00_fee0_0030, 1'b1);
        #1 cmp_val("irq_redirect", 40'h1, {39'h0, irq_redirect});
        cmp_val("irq_present", 40'h0, {39'h0, irq_present});
        oad_bus_model_i.message(40'h00_fee0_0040, 1'b1);
        #1 cmp_val("irq_other_node", 40'h0, {38'h0, irq_present, irq_redirect});
    endtask

    // --------------------------------------------------------------
    // main sequence and watchdog
    // --------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        srst_in = 1'b1;
        strap = 1'b1;
        bus = '0;
        repeat (16) @(posedge clk_in);
        srst_in <= 1'b0;
        t_reset_values();
        t_fixed_ranges();
        t_fw_hub();
        t_windows();
        t_irq();
        wrap_up();
    end

    // cuts a hang short
    initial begin
        repeat (20000) @(posedge clk_in);
        err_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
